//--- mem_map_pkg.sv
// Constants, types and field layout for the memory map and mode decoder.
// Assumes one 125 MHz clock and a synchronous, active-high reset.
// ****************************************
// Notes on behaviour
// ****************************************
package mem_map_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS     = 8;        // 125 MHz
  localparam int CHAR_TIME_NS      = 1041667;  // One 10-bit frame at 9600 baud
  localparam int IDLE_GAP_CHARS    = 4;        // Gap that ends loading
  localparam int MAP_WINDOW_CYCLES = 64;       // Mapping write window

  // ****************************************
  // Register offsets inside the block
  // ****************************************
  localparam logic [6:0] OFS_PAGE   = 7'h2d;  // Page select
  localparam logic [6:0] OFS_EE_POS = 7'h37;  // EEPROM position
  localparam logic [6:0] OFS_MODE   = 7'h3c;  // Mode bits
  localparam logic [6:0] OFS_MAP    = 7'h3d;  // RAM/register nibbles
  localparam logic [6:0] OFS_CFG    = 7'h3f;  // Configuration

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CFG_ROM_BASE_BIT = 7;
  localparam int CFG_FIXED_BIT    = 6;  // Reads as one
  localparam int CFG_ROM_EN_BIT   = 1;
  localparam int CFG_EE_EN_BIT    = 0;
  localparam int MODE_BOOT_BIT    = 7;
  localparam int MODE_SPECIAL_BIT = 6;
  localparam int MODE_SEL_A_BIT   = 5;

  // ****************************************
  // Address ranges (12-bit ones are offsets inside a 4 Kbyte page)
  // ****************************************
  localparam logic [11:0] REG_LAST      = 12'h07f;
  localparam logic [11:0] RAM_MAIN_1ST  = 12'h080;
  localparam logic [11:0] RAM_MAIN_LAST = 12'h2ff;
  localparam logic [11:0] RAM_ALT_1ST   = 12'h300;
  localparam logic [11:0] RAM_ALT_LAST  = 12'h37f;
  localparam logic [11:0] EE_1ST        = 12'hd80;
  localparam logic [11:0] PAGE_LAST     = 12'hfff;
  localparam logic [15:0] ROM_HI_1ST    = 16'ha000;
  localparam logic [15:0] ROM_LO_1ST    = 16'h2000;
  localparam logic [15:0] ROM_LO_LAST   = 16'h7fff;
  localparam logic [15:0] VECTOR_LAST   = 16'hffff;
  localparam logic [15:0] BOOT_JUMP     = 16'h0080;

  // ****************************************
  // RAM layout: 640-byte section first, 128 after
  // ****************************************
  localparam int          RAM_BYTES    = 768;
  localparam logic [9:0]  RAM_SMALL_IX = 10'h280;
  localparam logic [9:0]  RAM_LAST_IX  = 10'h2ff;  // Byte for $037F
  localparam logic [11:0] RAM_MAIN_OFS = 12'h080;
  localparam logic [7:0]  CFG_MASK_ONE = 8'h40;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    BOOT_IDLE = 2'b00,  // Not loading
    BOOT_LOAD = 2'b01,  // Receiving program
    BOOT_DONE = 2'b10   // Jump issued
  } boot_e;

  typedef struct packed {
    logic        valid;  // Access this cycle
    logic        write;  // One for write
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cpu_req_s;

  typedef struct packed {
    logic regs;
    logic ram;
    logic eeprom;
    logic rom;
    logic ext;
  } sel_s;

  typedef struct packed {
    logic       active;   // External cycle
    logic       rw;       // One for read
    logic [3:0] page;     // Paging bits
    logic [7:0] addr_hi;  // Port B
    logic [7:0] addr_lo;  // Port F
    logic [7:0] data_out; // Port C out
    logic       data_oe;  // Port C driven
  } ext_bus_s;

endpackage

//--- mem_map_decoder.sv
// Memory map, mode control, expansion bus and boot loader.
// Assumes inputs synchronous to clk and a serial receiver handing over bytes.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module mem_map_decoder #(
  parameter int BOOT_IDLE_CYCLES =
    mem_map_pkg::IDLE_GAP_CHARS * mem_map_pkg::CHAR_TIME_NS / mem_map_pkg::CLK_PERIOD_NS
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  mode_b_pin,   // Strap, low = special
  input  wire logic                  mode_a_pin,   // Strap
  input  wire logic [7:0]            nv_cfg,       // Nonvolatile config image
  input  wire logic [6:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [7:0]                 reg_rdata,
  input  mem_map_pkg::cpu_req_s      cpu,
  output logic [7:0]                 cpu_rdata,
  output logic                       cpu_rvalid,
  output mem_map_pkg::sel_s          sel,
  input  wire logic [7:0]            port_c_in,
  output mem_map_pkg::ext_bus_s      xbus,
  input  wire logic                  rx_valid,
  input  wire logic [7:0]            rx_data,
  output logic                       boot_busy,
  output logic                       jump_valid,
  output logic [15:0]                jump_addr
);
  import mem_map_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [7:0]  map_reg;          // RAM nibble high, register nibble low
  logic        map_done_reg;     // Normal-mode write used
  logic [6:0]  win_cnt_reg;      // Cycles since reset, saturating
  logic        special_mode_flag_reg;         // Special mode flag
  logic        mda_reg;          // Mode select A
  logic        mda_done_reg;     // Normal-mode write used
  logic        rboot_reg;        // Boot ROM shown
  logic [7:0]  cfg_reg;          // Configuration
  logic [3:0]  ee_pos_reg;       // EEPROM page
  logic [3:0]  page_reg;         // Paging bits
  boot_e       boot_reg;
  logic [9:0]  load_ix_reg;      // Next RAM byte to fill
  logic        loaded_any_reg;   // Gap timer armed
  logic [31:0] idle_reg;         // Cycles since last byte
  logic [7:0]  ram_mem [RAM_BYTES];
  logic [7:0]  ram_q_reg;        // RAM read stage
  logic        rd_pend_reg;      // Read in flight
  logic        rd_ram_reg;       // It was a RAM read
  logic        rd_ext_reg;       // It was an external read

  // Derived mode and map controls
  logic        single_chip;
  logic        expanded_bus;
  logic        test_mode;
  logic        rom_en;
  logic        rom_base;
  logic        win_open;
  sel_s        hit;
  logic [9:0]  ram_ix;
  logic [11:0] ofs;

  // ****************************************
  // Helpers
  // ****************************************
  // Offset window inside one 4 Kbyte page
  function automatic logic in_page(input logic [15:0] a, input logic [3:0] nib,
                                   input logic [11:0] lo, input logic [11:0] hi);
    in_page = (a[15:12] == nib) && (a[11:0] >= lo) && (a[11:0] <= hi);
  endfunction

  // Register port write to one offset
  function automatic logic wr_to(input logic [6:0] o);
    wr_to = reg_wr && (reg_addr == o);
  endfunction

  // ****************************************
  // Mode decode
  // ****************************************
  // Mode follows the live flag bits, so a cleared flag takes effect at once
  always_comb begin
    single_chip  = !special_mode_flag_reg && !mda_reg;
    expanded_bus = mda_reg;                // Expanded or test drive pins
    test_mode    = special_mode_flag_reg && mda_reg;
    rom_en       = cfg_reg[CFG_ROM_EN_BIT];
    // Single-chip pins the ROM to the top so vectors exist while ROM is enabled
    rom_base     = single_chip | cfg_reg[CFG_ROM_BASE_BIT];
    win_open     = win_cnt_reg < 7'(MAP_WINDOW_CYCLES);
    ofs          = cpu.addr[11:0];
  end

  // ****************************************
  // Reset window counter
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      win_cnt_reg <= '0;
    end else if (win_open) begin
      win_cnt_reg <= win_cnt_reg + 7'(1);
    end
  end

  // ****************************************
  // Mapping register
  // ****************************************
  // Normal modes get a single write, only inside the window
  always_ff @(posedge clk) begin
    if (rst) begin
      map_reg      <= '0;
      map_done_reg <= 1'b0;
    end else if (wr_to(OFS_MAP) && (special_mode_flag_reg || (!map_done_reg && win_open))) begin
      map_reg      <= reg_wdata;
      map_done_reg <= 1'b1;
    end
  end

  // ****************************************
  // Mode bits, latched from straps at reset
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      special_mode_flag_reg     <= !mode_b_pin;
      mda_reg      <= mode_a_pin;
      rboot_reg    <= !mode_b_pin && !mode_a_pin;
      mda_done_reg <= 1'b0;
    end else if (wr_to(OFS_MODE)) begin
      // Flag may only be cleared, never set again
      if (!reg_wdata[MODE_SPECIAL_BIT]) begin
        special_mode_flag_reg <= 1'b0;
      end
      // Select A: once in normal modes, freely in special
      if (special_mode_flag_reg || !mda_done_reg) begin
        mda_reg      <= reg_wdata[MODE_SEL_A_BIT];
        mda_done_reg <= 1'b1;
      end
      if (special_mode_flag_reg) begin
        rboot_reg <= reg_wdata[MODE_BOOT_BIT];
      end
    end
  end

  // ****************************************
  // Configuration, EEPROM position, paging
  // ****************************************
  // Test mode starts with ROM out of the map; software may bring it back
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg <= nv_cfg | CFG_MASK_ONE;
      if (!mode_b_pin && mode_a_pin) begin
        cfg_reg[CFG_ROM_EN_BIT] <= 1'b0;
      end
    end else if (wr_to(OFS_CFG) && special_mode_flag_reg) begin
      cfg_reg <= reg_wdata | CFG_MASK_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ee_pos_reg <= '0;
    end else if (wr_to(OFS_EE_POS)) begin
      ee_pos_reg <= reg_wdata[7:4];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      page_reg <= '0;
    end else if (wr_to(OFS_PAGE)) begin
      page_reg <= reg_wdata[3:0];
    end
  end

  // ****************************************
  // Register read port, data one cycle later
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == OFS_MAP) begin
      reg_rdata <= map_reg;
    end else if (reg_addr == OFS_MODE) begin
      reg_rdata <= {rboot_reg, special_mode_flag_reg, mda_reg, 5'h00};
    end else if (reg_addr == OFS_CFG) begin
      reg_rdata <= {rom_base, cfg_reg[6:0]};
    end else if (reg_addr == OFS_EE_POS) begin
      reg_rdata <= {ee_pos_reg, 4'h0};
    end else if (reg_addr == OFS_PAGE) begin
      reg_rdata <= {4'h0, page_reg};
    end else begin
      reg_rdata <= '0;  // Unmapped
    end
  end

  // ****************************************
  // Address decode, fixed priority
  // ****************************************
  // Registers over RAM over EEPROM over ROM; the rest goes outside when the bus is expanded
  always_comb begin
    hit    = '0;
    ram_ix = '0;
    if (in_page(cpu.addr, map_reg[3:0], '0, REG_LAST)) begin
      hit.regs = 1'b1;
    end else if (in_page(cpu.addr, map_reg[7:4], RAM_MAIN_1ST, RAM_MAIN_LAST)) begin
      hit.ram = 1'b1;
      ram_ix  = 10'(ofs - RAM_MAIN_OFS);
    end else if (map_reg[7:4] != map_reg[3:0] &&
                 in_page(cpu.addr, map_reg[7:4], '0, REG_LAST)) begin
      hit.ram = 1'b1;
      ram_ix  = RAM_SMALL_IX | 10'(ofs[6:0]);
    end else if (map_reg[7:4] == map_reg[3:0] &&
                 in_page(cpu.addr, map_reg[7:4], RAM_ALT_1ST, RAM_ALT_LAST)) begin
      hit.ram = 1'b1;
      ram_ix  = RAM_SMALL_IX | 10'(ofs[6:0]);
    end else if (cfg_reg[CFG_EE_EN_BIT] &&
                 in_page(cpu.addr, ee_pos_reg, EE_1ST, PAGE_LAST)) begin
      hit.eeprom = 1'b1;
    end else if (rom_en && (rom_base ? cpu.addr >= ROM_HI_1ST :
                 (cpu.addr >= ROM_LO_1ST && cpu.addr <= ROM_LO_LAST))) begin
      hit.rom = 1'b1;
    end else begin
      hit.ext = expanded_bus;
    end
  end

  // ****************************************
  // Access stage: selects and pins
  // ****************************************
  // Processor accesses are held off while the loader owns RAM
  always_ff @(posedge clk) begin
    if (rst || !cpu.valid || boot_reg == BOOT_LOAD) begin
      sel <= '0;
    end else begin
      sel <= hit;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !cpu.valid || boot_reg == BOOT_LOAD || !hit.ext) begin
      xbus    <= '0;
      xbus.rw <= 1'b1;
    end else begin
      xbus.active   <= 1'b1;
      xbus.rw       <= !cpu.write;
      xbus.data_oe  <= cpu.write;
      xbus.data_out <= cpu.wdata;
      xbus.addr_hi  <= cpu.addr[15:8];
      xbus.addr_lo  <= cpu.addr[7:0];
      xbus.page     <= page_reg;
    end
  end

  // ****************************************
  // RAM: loader has the port during load
  // ****************************************
  always_ff @(posedge clk) begin
    if (boot_reg == BOOT_LOAD && rx_valid) begin
      ram_mem[load_ix_reg] <= rx_data;
    end else if (cpu.valid && cpu.write && hit.ram && boot_reg != BOOT_LOAD) begin
      ram_mem[ram_ix] <= cpu.wdata;
    end
  end

  always_ff @(posedge clk) begin
    ram_q_reg <= ram_mem[ram_ix];
  end

  // ****************************************
  // Read return, two cycles after the request
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst || boot_reg == BOOT_LOAD) begin
      rd_pend_reg <= 1'b0;
      rd_ram_reg  <= 1'b0;
      rd_ext_reg  <= 1'b0;
    end else begin
      rd_pend_reg <= cpu.valid && !cpu.write;
      rd_ram_reg  <= cpu.valid && !cpu.write && hit.ram;
      rd_ext_reg  <= cpu.valid && !cpu.write && hit.ext;
    end
  end

  // External data is sampled while the pins still hold the cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_rvalid <= 1'b0;
      cpu_rdata  <= '0;
    end else begin
      cpu_rvalid <= rd_pend_reg;
      cpu_rdata  <= rd_ram_reg ? ram_q_reg : (rd_ext_reg ? port_c_in : '0);
    end
  end

  // ****************************************
  // Boot loader sequence
  // ****************************************
  // Gap timer only runs once a byte arrived, so a slow host is not cut off
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_reg       <= (!mode_b_pin && !mode_a_pin) ? BOOT_LOAD : BOOT_IDLE;
      load_ix_reg    <= '0;
      loaded_any_reg <= 1'b0;
      idle_reg       <= '0;
      jump_valid     <= 1'b0;
      jump_addr      <= '0;
    end else begin
      jump_valid <= 1'b0;
      case (boot_reg)
        BOOT_LOAD: begin
          if (rx_valid) begin
            load_ix_reg    <= load_ix_reg + 10'(1);
            loaded_any_reg <= 1'b1;
            idle_reg       <= '0;
            if (load_ix_reg == RAM_LAST_IX) begin
              boot_reg   <= BOOT_DONE;
              jump_valid <= 1'b1;
              jump_addr  <= BOOT_JUMP;
            end
          end else if (loaded_any_reg) begin
            if (idle_reg >= 32'(BOOT_IDLE_CYCLES - 1)) begin
              boot_reg   <= BOOT_DONE;
              jump_valid <= 1'b1;
              jump_addr  <= BOOT_JUMP;
            end else begin
              idle_reg <= idle_reg + 32'(1);
            end
          end
        end
        BOOT_DONE: begin
          boot_reg <= BOOT_DONE;
        end
        default: begin
          boot_reg <= BOOT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      boot_busy <= 1'b0;
    end else begin
      boot_busy <= boot_reg == BOOT_LOAD;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_SINGLE_QUIET: assert property (
    cpu.valid && single_chip |=> !xbus.active && !xbus.data_oe)
    else $error("external activity in single-chip mode");

  AST_EXT_ADDR: assert property (
    cpu.valid && hit.ext && boot_reg != BOOT_LOAD |=>
      xbus.active && xbus.addr_hi == $past(cpu.addr[15:8]) &&
      xbus.addr_lo == $past(cpu.addr[7:0]))
    else $error("external address not on pins");

  AST_DATA_DIR: assert property (
    xbus.data_oe |-> xbus.active && !xbus.rw)
    else $error("port C driven outside a write");

  AST_BOOT_LAST: assert property (
    boot_reg == BOOT_LOAD && rx_valid && load_ix_reg == RAM_LAST_IX |=>
      jump_valid && jump_addr == BOOT_JUMP ##1 !jump_valid)
    else $error("no jump after last boot byte");

  AST_MAP_LOCK: assert property (
    !special_mode_flag_reg && !win_open && wr_to(OFS_MAP) |=> $stable(map_reg))
    else $error("mapping changed after window");

  AST_REG_WINS: assert property (
    cpu.valid && hit.regs && boot_reg != BOOT_LOAD |=> sel.regs && !sel.ram)
    else $error("register block lost priority");

  AST_VECTORS: assert property (
    cpu.valid && single_chip && rom_en && cpu.addr == VECTOR_LAST &&
    map_reg[3:0] != VECTOR_LAST[15:12] && map_reg[7:4] != VECTOR_LAST[15:12] &&
    boot_reg != BOOT_LOAD |=> sel.rom)
    else $error("vector space not in ROM");

  AST_TEST_ROM_OFF: assert property (
    $fell(rst) && test_mode |-> !rom_en)
    else $error("ROM enabled out of reset in test mode");

  AST_FLAG_STAYS: assert property (
    !special_mode_flag_reg |=> !special_mode_flag_reg [*2])
    else $error("special mode flag set again");

  COV_BOOT_DONE: cover property (boot_reg == BOOT_LOAD ##1 jump_valid);
  COV_EXT_WRITE: cover property (xbus.data_oe);
  COV_RAM_ALT:   cover property (cpu.valid && hit.ram && map_reg[7:4] == map_reg[3:0] &&
                                 ofs >= RAM_ALT_1ST);
  COV_MAP_MOVE:  cover property (wr_to(OFS_MAP) ##1 map_reg != '0);

endmodule

//--- ext_mem.sv
// External memory model on the expansion bus.
// Assumes the decoder's bus outputs are registered on the rising edge of clk.
`timescale 1ns/1ps
module ext_mem (
  input  wire logic           clk,
  input  mem_map_pkg::ext_bus_s xbus,
  output logic [7:0]          port_c_in
);
  import mem_map_pkg::*;
  // ****************************************
  // Storage and released-bus pattern
  // ****************************************
  logic [7:0]  mem [0:65535];        // Byte store
  logic [7:0]  last_reg = 8'h00;     // Last value seen on port C
  wire  [15:0] addr = {xbus.addr_hi, xbus.addr_lo};
  // Drive only in read cycles; otherwise flip, so a stale value never passes
  assign port_c_in = (xbus.active && xbus.rw) ? mem[addr] : ~last_reg;
  // Capture data while the decoder drives port C
  always_ff @(posedge clk) begin
    if (xbus.active && !xbus.rw && xbus.data_oe) begin
      mem[addr] <= xbus.data_out;
    end
    last_reg <= port_c_in;
  end
endmodule

//--- tb_top.sv
// Self-checking bench for the memory map and mode decoder.
// Assumes mem_map_pkg and ext_mem are compiled first.
`timescale 1ns/1ps
module tb_top;
  import mem_map_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  localparam logic [4:0] S_REG = 5'h10, S_RAM = 5'h08, S_EE = 5'h04;
  localparam logic [4:0] S_ROM = 5'h02, S_EXT = 5'h01, S_NONE = 5'h00;
  logic        clk = 1'b0, rst = 1'b1, mode_b_pin = 1'b1, mode_a_pin = 1'b1;
  logic [7:0]  nv_cfg = 8'h40, reg_wdata = 8'h00, rx_data = 8'h00;
  logic [7:0]  port_c_in, reg_rdata, cpu_rdata;
  logic [6:0]  reg_addr = 7'h00;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, rx_valid = 1'b0;
  logic        cpu_rvalid, boot_busy, jump_valid;
  logic [15:0] jump_addr;
  cpu_req_s    cpu = '0;
  sel_s        sel;
  ext_bus_s    xbus;
  int          failures = 0, cmp_count = 0, cycles = 0;
  logic [3:0]  exp_page = 4'h0;  // Page bits expected on external cycles
  // Short idle gap keeps the boot run brief
  mem_map_decoder #(.BOOT_IDLE_CYCLES(20)) dut_u (.clk(clk), .rst(rst),
    .mode_b_pin(mode_b_pin), .mode_a_pin(mode_a_pin), .nv_cfg(nv_cfg),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu(cpu), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .sel(sel), .port_c_in(port_c_in), .xbus(xbus), .rx_valid(rx_valid),
    .rx_data(rx_data), .boot_busy(boot_busy), .jump_valid(jump_valid),
    .jump_addr(jump_addr));
  ext_mem ext_u (.clk(clk), .xbus(xbus), .port_c_in(port_c_in));
  // 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end
  // Hang guard, far above the expected run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      end_sim();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Straps and config are sampled while reset is high
  task automatic do_reset(input logic b, input logic a, input logic [7:0] cfg);
    @(posedge clk);
    rst <= 1'b1;
    mode_b_pin <= b;
    mode_a_pin <= a;
    nv_cfg <= cfg;
    exp_page = 4'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic reg_w(input logic [6:0] o, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= o;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_r(input logic [6:0] o, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= o;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  // One processor access: select and bus one cycle on, read data after that
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                     input logic [4:0] es, input logic [7:0] ed);
    @(posedge clk);
    cpu <= '{1'b1, w, a, d};
    @(posedge clk);
    cpu <= '0;
    #1 chk({11'h0, sel}, {11'h0, es});
    chk({13'h0, xbus.active, xbus.rw, xbus.data_oe},
        {13'h0, es[0], ~(w & es[0]), w & es[0]});
    if (es[0]) chk({xbus.addr_hi, xbus.addr_lo}, a);
    if (es[0]) chk({12'h0, xbus.page}, {12'h0, exp_page});
    if (es[0] && w) chk({8'h00, xbus.data_out}, {8'h00, d});
    @(posedge clk);
    // Every read outside a boot load answers, unclaimed ones with zero data
    #1 if (!w) chk({7'h0, cpu_rvalid, cpu_rdata}, {7'h0, 1'b1, ed});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_exp;
    do_reset(1'b1, 1'b1, 8'h41);
    reg_r(OFS_MAP, 8'h00);
    reg_w(OFS_MAP, 8'h21);
    reg_w(OFS_MAP, 8'h45);
    reg_r(OFS_MAP, 8'h21);
    reg_w(7'h10, 8'hff);
    reg_r(7'h10, 8'h00);
    acc(1'b0, 16'h1000, 8'h00, S_REG, 8'h00);
    acc(1'b1, 16'h2100, 8'h3c, S_RAM, 8'h00);
    acc(1'b0, 16'h2100, 8'h00, S_RAM, 8'h3c);
    acc(1'b1, 16'h2000, 8'h77, S_RAM, 8'h00);
    acc(1'b0, 16'h2000, 8'h00, S_RAM, 8'h77);
    acc(1'b1, 16'h2300, 8'h11, S_EXT, 8'h00);
    acc(1'b0, 16'h0d80, 8'h00, S_EE, 8'h00);
    reg_w(OFS_EE_POS, 8'h40);
    acc(1'b0, 16'h4fff, 8'h00, S_EE, 8'h00);
    reg_w(OFS_PAGE, 8'h05);
    exp_page = 4'h5;
    reg_r(OFS_PAGE, 8'h05);
    acc(1'b1, 16'hf123, 8'h96, S_EXT, 8'h00);
    acc(1'b0, 16'hf123, 8'h00, S_EXT, 8'h96);
  endtask
  task automatic t_single;
    do_reset(1'b1, 1'b0, 8'h42);
    acc(1'b0, 16'ha000, 8'h00, S_ROM, 8'h00);
    acc(1'b0, 16'hffff, 8'h00, S_ROM, 8'h00);
    acc(1'b0, 16'h3000, 8'h00, S_NONE, 8'h00);
    acc(1'b0, 16'h0d80, 8'h00, S_NONE, 8'h00);
    acc(1'b1, 16'h4123, 8'h5a, S_NONE, 8'h00);
    reg_r(OFS_CFG, 8'hc2);
    repeat (70) @(posedge clk);
    reg_w(OFS_MAP, 8'h11);
    reg_r(OFS_MAP, 8'h00);
  endtask
  task automatic t_test;
    do_reset(1'b0, 1'b1, 8'hc2);
    reg_r(OFS_CFG, 8'hc0);
    acc(1'b1, 16'ha000, 8'h5e, S_EXT, 8'h00);
    reg_w(OFS_CFG, 8'hc2);
    acc(1'b0, 16'ha000, 8'h00, S_ROM, 8'h00);
    reg_w(OFS_MAP, 8'h11);
    reg_w(OFS_MAP, 8'h33);
    reg_r(OFS_MAP, 8'h33);
    reg_r(OFS_MODE, 8'h60);
    reg_w(OFS_MODE, 8'h40);
    reg_r(OFS_MODE, 8'h40);
    reg_w(OFS_MODE, 8'h00);
    reg_w(OFS_MODE, 8'h40);
    reg_r(OFS_MODE, 8'h00);
  endtask
  // Loads n bytes back to back; a full load ends at once, a short one on idle
  task automatic t_boot(input int n);
    int k;
    do_reset(1'b0, 1'b0, 8'h40);
    #1 chk({15'h0, boot_busy}, 16'h0001);
    // Processor writes are dropped while the loader owns RAM
    acc(1'b1, 16'h0080, 8'h33, S_NONE, 8'h00);
    for (k = 0; k < n; k++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= 8'(k) ^ 8'h5a;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    #1 if (n == 768) chk({15'h0, jump_valid}, 16'h0001);
    if (n != 768) begin
      k = 0;
      while (jump_valid !== 1'b1 && k < 40) begin
        @(posedge clk);
        #1 k++;
      end
      chk({15'h0, (k >= 10 && k < 40)}, 16'h0001);
    end
    chk(jump_addr, 16'h0080);
    acc(1'b0, 16'h0080, 8'h00, S_RAM, 8'h5a);
    chk({15'h0, boot_busy}, 16'h0000);
    if (n == 768) acc(1'b0, 16'h037f, 8'h00, S_RAM, 8'ha5);
    acc(1'b0, 16'h0000, 8'h00, S_REG, 8'h00);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    t_exp();
    t_single();
    t_test();
    t_boot(3);
    t_boot(768);
    end_sim();
  end
endmodule
